// ==== rtl/scr_ctrl_bank.sv ====
// Control register bank of the codec, reached by secondary serial words.
//
// Behaviour
// - Word bits 12..8 address, 7..0 data.
// - Bit 13 low writes, high reads.
// - Address 0 no-op; 1 to 4 registers.
// - Control one bit 7 self-clearing software reset.
// - Control one bit 6 software power-down.
// - Control one bit 5 selects auxiliary converter input.
// - Control one bit 4 selects auxiliary monitor input.
// - Control one bits 3..2 monitor gain.
// - Control one bit 1 digital loopback.
// - Control one bit 0 selects 16-bit DAC mode.
// - Control two bit 5 reads decimator overflow.
// - Control three low six bits: delay clocks.
// - Control three bits 7..6 slave count.
// - Control four bits 3..2 input gain.
// - Control four bits 1..0 output gain.
// - Control four bits 6..4 divisor, zero means eight.
// - Control four bit 7 external sample clock.
// - Phone mode drives flag outputs from control two.
// - Phone mode routes alternate input to output.
// - Hardware reset returns registers to defaults.
`timescale 1ns/1ps
`default_nettype none
module scr_ctrl_bank (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic frame_sync_n,
   input wire logic din,
   input wire logic sec_frame,
   input wire logic alternate_data_input,
   input wire logic decim_overflow,
   output logic dout,
   output logic dout_oe,
   output logic delayed_frame_sync_n,
   output logic flag0,
   output logic flag1,
   output logic soft_reset,
   output logic soft_powerdown,
   output logic adc_aux_sel,
   output logic monitor_aux_sel,
   output logic [1:0] monitor_gain,
   output logic digital_loopback,
   output logic dac16_mode,
   output logic adc16_mode,
   output logic analog_loopback,
   output logic phone_mode,
   output logic [1:0] slave_count,
   output logic [1:0] input_gain,
   output logic [1:0] output_gain,
   output logic [3:0] sample_divisor,
   output logic ext_sample_clk_en
);
   import scr_pkg::*;

   scr_word_if w (); // Link between shifter and bank.

   logic [7:0] ctrl1_ff; // reset_power_input_select.
   logic [7:0] ctrl2_ff; // flag_phone_loopback_config, bit 5 kept zero.
   logic [7:0] ctrl3_ff; // frame_delay_slave_count.
   logic [7:0] ctrl4_ff; // gain_and_sample_rate.
   logic swrst_ff; // One-cycle software reset pulse.
   logic ovf_ff; // Overflow status sampled every cycle.
   logic flag_ff; // Flag output value.
   logic [3:0] div_ff; // Decoded sample divisor.
   logic fsd_n_ff; // Delayed frame sync, active low.
   logic [5:0] fsd_cnt_ff; // Shift clocks still to wait.
   scr_fsd_state_t fsd_st_ff; // Delayed frame sync sequencer state.
   scr_fsd_state_t nxt_fsd_st; // Its next value.
   logic wr1, wr2, wr3, wr4; // Write strobes per register.
   logic any_wr; // A register write this cycle.

   // True when the word is a write to the given address, upper bits zero.
   function automatic logic wr_to(input logic [15:0] wd, input logic [4:0] addr);
      wr_to = (wd[15:ADDR_LSB] == {3'b000, addr});
   endfunction

   // Byte that a read of the given header returns; others read zero.
   function automatic logic [7:0] rd_sel(input logic [7:0] hd, input logic [7:0] c1,
         input logic [7:0] c2, input logic [7:0] c3, input logic [7:0] c4);
      rd_sel = 8'h00;
      if (hd[7:6] == 2'b00 && hd[RW_BIT - ADDR_LSB]) begin
         case (hd[ADDR_W-1:0])
            ADDR_CTRL1: rd_sel = c1;
            ADDR_CTRL2: rd_sel = c2;
            ADDR_CTRL3: rd_sel = c3;
            ADDR_CTRL4: rd_sel = c4;
            default: rd_sel = 8'h00;
         endcase
      end
   endfunction

   // Serial shifter that frames the secondary words.
   scr_serial u_serial (
      .mclk(mclk),
      .rst_n(rst_n),
      .sclk(sclk),
      .frame_sync_n(frame_sync_n),
      .din(din),
      .sec_frame(sec_frame),
      .alternate_data_input(alternate_data_input),
      .dout(dout),
      .dout_oe(dout_oe),
      .w(w.ser)
   );

   // Write decode; a read or address 0 matches none of them.
   assign wr1 = w.word_stb && wr_to(w.word, ADDR_CTRL1);
   assign wr2 = w.word_stb && wr_to(w.word, ADDR_CTRL2);
   assign wr3 = w.word_stb && wr_to(w.word, ADDR_CTRL3);
   assign wr4 = w.word_stb && wr_to(w.word, ADDR_CTRL4);
   assign any_wr = wr1 || wr2 || wr3 || wr4;

   // Read data, with the live overflow status in place of bit 5.
   assign w.rd_byte = rd_sel(w.hdr, ctrl1_ff,
      {ctrl2_ff[7:6], ovf_ff, ctrl2_ff[4:0]}, ctrl3_ff, ctrl4_ff);
   assign w.phone_mode = ctrl2_ff[C2_PHONE];

   // Register fields driven from the register flops; divisor, flags and reset pulse come from their own flops.
   assign soft_reset = swrst_ff;
   assign soft_powerdown = ctrl1_ff[C1_PWDN];
   assign adc_aux_sel = ctrl1_ff[C1_ADC_AUX];
   assign monitor_aux_sel = ctrl1_ff[C1_MON_AUX];
   assign monitor_gain = ctrl1_ff[C1_MONG +: 2];
   assign digital_loopback = ctrl1_ff[C1_DLOOP];
   assign dac16_mode = ctrl1_ff[C1_DAC16];
   assign adc16_mode = ctrl2_ff[C2_ADC16];
   assign analog_loopback = ctrl2_ff[C2_ALOOP];
   assign phone_mode = ctrl2_ff[C2_PHONE];
   assign slave_count = ctrl3_ff[C3_SLAVE +: 2];
   assign input_gain = ctrl4_ff[C4_IGAIN +: 2];
   assign output_gain = ctrl4_ff[C4_OGAIN +: 2];
   assign ext_sample_clk_en = ctrl4_ff[C4_EXTCLK];
   assign sample_divisor = div_ff;
   assign flag0 = flag_ff;
   assign flag1 = flag_ff;
   assign delayed_frame_sync_n = fsd_n_ff;

   // Control one; a set reset bit clears the whole bank and is never stored.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl1_ff <= CTRL1_RST;
      end else if (wr1 && w.word[C1_SWRST]) begin
         ctrl1_ff <= CTRL1_RST;
      end else if (wr1) begin
         ctrl1_ff <= {1'b0, w.word[6:0]};
      end
   end

   // Control two; the overflow bit is status and is not stored.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl2_ff <= CTRL2_RST;
      end else if (wr1 && w.word[C1_SWRST]) begin
         ctrl2_ff <= CTRL2_RST;
      end else if (wr2) begin
         ctrl2_ff <= {w.word[7:6], 1'b0, w.word[4:0]};
      end
   end

   // Control three holds the delay count and the slave count.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl3_ff <= CTRL3_RST;
      end else if (wr1 && w.word[C1_SWRST]) begin
         ctrl3_ff <= CTRL3_RST;
      end else if (wr3) begin
         ctrl3_ff <= w.word[7:0];
      end
   end

   // Control four holds gains, divisor and the external clock enable.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl4_ff <= CTRL4_RST;
      end else if (wr1 && w.word[C1_SWRST]) begin
         ctrl4_ff <= CTRL4_RST;
      end else if (wr4) begin
         ctrl4_ff <= w.word[7:0];
      end
   end

   // Software reset pulse, one cycle, then it ends on its own.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         swrst_ff <= 1'b0;
      end else begin
         swrst_ff <= wr1 && w.word[C1_SWRST];
      end
   end

   // Status sample, flag pins and decoded divisor.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ovf_ff <= 1'b0;
         flag_ff <= 1'b0;
         div_ff <= DIV_ZERO_N;
      end else begin
         ovf_ff <= decim_overflow;
         flag_ff <= ctrl2_ff[C2_PHONE] && ctrl2_ff[C2_FLAG];
         if (ctrl4_ff[C4_DIV +: 3] == 3'h0) begin
            div_ff <= DIV_ZERO_N;
         end else begin
            div_ff <= {1'b0, ctrl4_ff[C4_DIV +: 3]};
         end
      end
   end

   // Next state of the delayed frame sync sequencer.
   always_comb begin
      nxt_fsd_st = fsd_st_ff;
      case (fsd_st_ff)
         FSD_IDLE: begin
            if (w.fs_fall && ctrl3_ff[C3_DELAY_W-1:0] == 6'h00) begin
               nxt_fsd_st = FSD_PULSE;
            end else if (w.fs_fall) begin
               nxt_fsd_st = FSD_COUNT;
            end
         end
         FSD_COUNT: begin
            if (frame_sync_n && !w.sclk_rise) begin
               nxt_fsd_st = FSD_IDLE;
            end else if (w.sclk_rise && fsd_cnt_ff == 6'h01) begin
               nxt_fsd_st = FSD_PULSE;
            end
         end
         FSD_PULSE: begin
            if (w.sclk_rise) begin
               nxt_fsd_st = FSD_WAIT;
            end
         end
         FSD_WAIT: begin
            if (frame_sync_n) begin
               nxt_fsd_st = FSD_IDLE;
            end
         end
         default: nxt_fsd_st = FSD_IDLE;
      endcase
   end

   // Counts shift clocks after frame sync and drives the delayed pulse.
   always_ff @(posedge mclk) begin
      if (!rst_n || swrst_ff) begin
         fsd_st_ff <= FSD_IDLE;
         fsd_cnt_ff <= 6'h00;
         fsd_n_ff <= 1'b1;
      end else begin
         fsd_st_ff <= nxt_fsd_st;
         if (w.fs_fall) begin
            fsd_cnt_ff <= ctrl3_ff[C3_DELAY_W-1:0];
         end else if (fsd_st_ff == FSD_COUNT && w.sclk_rise) begin
            fsd_cnt_ff <= fsd_cnt_ff - 6'h01;
         end
         fsd_n_ff <= !(nxt_fsd_st == FSD_PULSE);
      end
   end

   // Helper for checking: shift clock rises since the frame sync fell.
   logic [6:0] since_fs_ff;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         since_fs_ff <= 7'h00;
      end else if (w.fs_fall) begin
         since_fs_ff <= 7'h00;
      end else if (w.sclk_rise && since_fs_ff != 7'h7f) begin
         since_fs_ff <= since_fs_ff + 7'h01;
      end
   end

   // Helper for checking: the delay count in force for this frame. A write to control
   // three inside the frame must not move the expected pulse position.
   logic [5:0] fs_delay_ff;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fs_delay_ff <= 6'h00;
      end else if (w.fs_fall) begin
         fs_delay_ff <= ctrl3_ff[C3_DELAY_W-1:0];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   write_store_a: assert property (wr4 |=> ctrl4_ff == $past(w.word[7:0]))
      else $error("control four did not take the written byte");
   read_keeps_a: assert property (w.word_stb && w.word[RW_BIT]
      |=> $stable({ctrl1_ff, ctrl2_ff, ctrl3_ff, ctrl4_ff}))
      else $error("a read changed a register");
   nop_address_a: assert property (w.word_stb && w.word[12:8] == ADDR_NOP
      |=> $stable({ctrl1_ff, ctrl2_ff, ctrl3_ff, ctrl4_ff}))
      else $error("address zero changed a register");
   swrst_clear_a: assert property (wr1 && w.word[C1_SWRST]
      |=> soft_reset && ctrl1_ff == CTRL1_RST ##1 !soft_reset)
      else $error("software reset not a single self-clearing pulse");
   ctrl1_fields_a: assert property (wr1 && !w.word[C1_SWRST]
      |=> {soft_powerdown, adc_aux_sel, monitor_aux_sel, monitor_gain, digital_loopback,
      dac16_mode} == $past(w.word[6:0]))
      else $error("control one fields do not follow the write");
   ovf_read_a: assert property (w.hdr == {2'b00, 1'b1, ADDR_CTRL2}
      |-> w.rd_byte[C2_OVF] == ovf_ff)
      else $error("overflow status missing from read byte");
   // The pulse is held against the count latched at the frame start, not the live field.
   fsd_delay_a: assert property ($fell(delayed_frame_sync_n)
      |-> since_fs_ff == {1'b0, fs_delay_ff})
      else $error("delayed frame sync at the wrong shift clock");
   ctrl4_fields_a: assert property (wr4
      |=> {ext_sample_clk_en, input_gain, output_gain} == {$past(w.word[7]), $past(w.word[3:0])})
      else $error("control four fields do not follow the write");
   slave_count_a: assert property (wr3 |=> slave_count == $past(w.word[7:6]))
      else $error("slave count does not follow the write");
   divisor_a: assert property (wr4 && w.word[6:4] == 3'h0
      |-> ##2 sample_divisor == DIV_ZERO_N)
      else $error("zero divisor field did not select eight");
   flag_out_a: assert property (phone_mode ##1 phone_mode
      |-> flag0 == $past(ctrl2_ff[C2_FLAG]) && flag1 == flag0)
      else $error("flag outputs do not show the programmed value");
   hw_reset_a: assert property (@(posedge mclk) disable iff (1'b0) !rst_n
      |=> ctrl1_ff == CTRL1_RST && ctrl2_ff == CTRL2_RST && ctrl3_ff == CTRL3_RST
      && ctrl4_ff == CTRL4_RST)
      else $error("registers not at defaults after reset");

   read_ctrl2_c: cover property (w.word_stb && w.word[15:8] == {2'b00, 1'b1, ADDR_CTRL2});
   swrst_c: cover property (soft_reset);
   fsd_pulse_c: cover property ($fell(delayed_frame_sync_n) && ctrl3_ff[5:0] == 6'd18);
   phone_flag_c: cover property (phone_mode && flag0);
   write_c: cover property (any_wr);
endmodule
`default_nettype wire

// ==== rtl/scr_pkg.sv ====
// Package with the register map, field positions, counts and state codes of the control bank.
package scr_pkg;
   // Secondary word layout.
   localparam int WORD_W = 16;
   localparam int RW_BIT = 13;
   localparam int ADDR_LSB = 8;
   localparam int ADDR_W = 5;
   localparam logic [4:0] CNT_WORD = 5'h10; // Shift clocks in one secondary word.
   localparam logic [4:0] CNT_HDR = 5'h08; // Shift clocks before the data byte starts.
   // Register addresses.
   localparam logic [4:0] ADDR_NOP = 5'h00;
   localparam logic [4:0] ADDR_CTRL1 = 5'h01;
   localparam logic [4:0] ADDR_CTRL2 = 5'h02;
   localparam logic [4:0] ADDR_CTRL3 = 5'h03;
   localparam logic [4:0] ADDR_CTRL4 = 5'h04;
   // Reset values.
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] CTRL3_RST = 8'h00;
   localparam logic [7:0] CTRL4_RST = 8'h00;
   // Field positions of reset_power_input_select.
   localparam int C1_SWRST = 7;
   localparam int C1_PWDN = 6;
   localparam int C1_ADC_AUX = 5;
   localparam int C1_MON_AUX = 4;
   localparam int C1_MONG = 2;
   localparam int C1_DLOOP = 1;
   localparam int C1_DAC16 = 0;
   // Field positions of flag_phone_loopback_config.
   localparam int C2_FLAG = 7;
   localparam int C2_PHONE = 6;
   localparam int C2_OVF = 5;
   localparam int C2_ADC16 = 4;
   localparam int C2_ALOOP = 3;
   // Field positions of frame_delay_slave_count and gain_and_sample_rate.
   localparam int C3_DELAY_W = 6;
   localparam int C3_SLAVE = 6;
   localparam int C4_OGAIN = 0;
   localparam int C4_IGAIN = 2;
   localparam int C4_DIV = 4;
   localparam int C4_EXTCLK = 7;
   // Divisor value selected by a zero field.
   localparam logic [3:0] DIV_ZERO_N = 4'h8;
   // Delayed frame sync sequencer states.
   typedef enum logic [3:0] {
      FSD_IDLE = 4'b0001,
      FSD_COUNT = 4'b0010,
      FSD_PULSE = 4'b0100,
      FSD_WAIT = 4'b1000
   } scr_fsd_state_t;
endpackage

// ==== rtl/scr_word_if.sv ====
// Interface that joins the serial shifter to the register bank.
`timescale 1ns/1ps
`default_nettype none
interface scr_word_if;
   logic word_stb; // One-cycle pulse, a whole secondary word has arrived.
   logic [15:0] word; // Received secondary word.
   logic [7:0] hdr; // Upper byte of the word being received.
   logic [7:0] rd_byte; // Register byte to send back in a read.
   logic phone_mode; // Phone mode is enabled.
   logic sclk_rise; // Shift clock rose this cycle.
   logic fs_fall; // Frame sync fell this cycle.
   modport ser (output word_stb, word, hdr, sclk_rise, fs_fall, input rd_byte, phone_mode);
   modport bank (input word_stb, word, hdr, sclk_rise, fs_fall, output rd_byte, phone_mode);
endinterface
`default_nettype wire

// ==== rtl/scr_serial.sv ====
// Serial shifter that receives secondary words and drives the data output.
`timescale 1ns/1ps
`default_nettype none
module scr_serial (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic frame_sync_n,
   input wire logic din,
   input wire logic sec_frame,
   input wire logic alternate_data_input,
   output logic dout,
   output logic dout_oe,
   scr_word_if.ser w
);
   import scr_pkg::*;

   logic sclk_q_ff; // Shift clock of the previous cycle.
   logic fs_q_ff; // Frame sync of the previous cycle.
   logic [15:0] shift_ff; // Incoming bits, first bit ends at the top.
   logic [4:0] cnt_ff; // Bits taken in this frame.
   logic [7:0] hdr_ff; // Upper byte, held once eight bits are in.
   logic stb_ff; // Word complete pulse.
   logic sclk_fall;

   assign sclk_fall = !sclk && sclk_q_ff;
   assign w.sclk_rise = sclk && !sclk_q_ff;
   assign w.fs_fall = !frame_sync_n && fs_q_ff;
   assign w.word = shift_ff;
   assign w.word_stb = stb_ff;
   assign w.hdr = hdr_ff;

   // Remembers the serial pins one cycle back for edge detection.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sclk_q_ff <= 1'b0;
         fs_q_ff <= 1'b1;
      end else begin
         sclk_q_ff <= sclk;
         fs_q_ff <= frame_sync_n;
      end
   end

   // Takes a bit on each of the first 16 falling shift clocks inside a secondary frame.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shift_ff <= 16'h0000;
         cnt_ff <= 5'h00;
         hdr_ff <= 8'h00;
         stb_ff <= 1'b0;
      end else begin
         stb_ff <= 1'b0;
         if (frame_sync_n || !sec_frame) begin
            cnt_ff <= 5'h00;
         end else if (sclk_fall && cnt_ff != CNT_WORD) begin
            shift_ff <= {shift_ff[14:0], din};
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == CNT_HDR - 5'h01) begin
               hdr_ff <= {shift_ff[6:0], din};
            end
            if (cnt_ff == CNT_WORD - 5'h01) begin
               stb_ff <= 1'b1;
            end
         end
      end
   end

   // Drives the output pin; phone mode passes the alternate input through.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dout <= 1'b0;
         dout_oe <= 1'b0;
      end else begin
         dout_oe <= !frame_sync_n && sec_frame;
         if (w.phone_mode) begin
            dout <= alternate_data_input;
         end else if (cnt_ff >= CNT_HDR && cnt_ff < CNT_WORD && hdr_ff[RW_BIT - ADDR_LSB]) begin
            dout <= w.rd_byte[~cnt_ff[2:0]];
         end else begin
            dout <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   alt_route_a: assert property (w.phone_mode |=> dout == $past(alternate_data_input))
      else $error("alternate data not routed to output");
   readback_a: assert property (!w.phone_mode && cnt_ff == CNT_HDR && hdr_ff[5]
      |=> dout == $past(w.rd_byte[7]))
      else $error("read byte msb not on output");
endmodule
`default_nettype wire

// ==== test/scr_host_model.sv ====
// Host serial port model that frames secondary words and gathers the device's answers.
`timescale 1ns/1ps
`default_nettype none
module scr_host_model #(
   parameter int PH = 4,
   parameter int NBIT = 24
) (
   input wire logic mclk,
   input wire logic dout,
   input wire logic delayed_frame_sync_n,
   output logic sclk,
   output logic frame_sync_n,
   output logic din,
   output logic sec_frame
);
   // The port idles with the frame closed and the shift clock standing low.
   initial begin
      sclk = 1'b0;
      frame_sync_n = 1'b1;
      din = 1'b0;
      sec_frame = 1'b0;
   end
   // One framed word, padded with extra clocks so that long sync delays can finish.
   task automatic xfer(input logic [15:0] w, output logic [7:0] rd, output int fsd_at);
      int i;
      rd = 8'h00;
      fsd_at = 0;
      @(negedge mclk);
      frame_sync_n = 1'b0;
      sec_frame = 1'b1;
      for (i = 0; i < NBIT; i++) begin
         @(negedge mclk);
         sclk = 1'b1;
         // Padding bits toggle so the device never sees a settled line.
         din = (i < 16) ? w[15 - i] : ~din;
         repeat (PH - 1) @(negedge mclk);
         // The read byte rides in bit slots 8 to 15, the low byte of the word, first bit highest.
         if (i >= 8 && i < 16) begin
            rd = {rd[6:0], dout};
         end
         @(negedge mclk);
         sclk = 1'b0;
         repeat (PH - 1) @(negedge mclk);
         // The delayed sync pulse holds low until the next rise, so look late.
         if (delayed_frame_sync_n === 1'b0 && fsd_at == 0) begin
            fsd_at = i + 1;
         end
      end
      @(negedge mclk);
      frame_sync_n = 1'b1;
      sec_frame = 1'b0;
      din = ~din;
      repeat (6) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking testbench of the control register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import scr_pkg::*;
   logic mclk, rst_n, sclk, frame_sync_n, din, sec_frame, alt, ovf;
   logic dout, dout_oe, fsd_n, flag0, flag1, soft_reset, pd, adc_aux, mon_aux;
   logic [1:0] mon_g, slave_count, input_gain, output_gain;
   logic dloop, dac16, adc16, aloop, phone, ext_clk;
   logic [3:0] sample_divisor;
   logic [22:0] fields; // All field outputs except the reset pulse, packed in a fixed order.
   logic [7:0] rg [1:4]; // Expected register contents.
   logic [7:0] rb, d;
   int err_count = 0, num_checks = 0, cyc = 0, sr_cnt = 0, fa, j, k;
   assign fields = {pd, adc_aux, mon_aux, mon_g, dloop, dac16, flag0, flag1, adc16, aloop,
                    phone, slave_count, input_gain, output_gain, sample_divisor, ext_clk};
   // The clock toggles every half period of 5 ns.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   scr_ctrl_bank u_dut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .frame_sync_n(frame_sync_n),
      .din(din), .sec_frame(sec_frame), .alternate_data_input(alt), .decim_overflow(ovf),
      .dout(dout), .dout_oe(dout_oe), .delayed_frame_sync_n(fsd_n), .flag0(flag0),
      .flag1(flag1), .soft_reset(soft_reset), .soft_powerdown(pd), .adc_aux_sel(adc_aux),
      .monitor_aux_sel(mon_aux), .monitor_gain(mon_g), .digital_loopback(dloop),
      .dac16_mode(dac16), .adc16_mode(adc16), .analog_loopback(aloop), .phone_mode(phone),
      .slave_count(slave_count), .input_gain(input_gain), .output_gain(output_gain),
      .sample_divisor(sample_divisor), .ext_sample_clk_en(ext_clk));
   scr_host_model u_host (.mclk(mclk), .dout(dout), .delayed_frame_sync_n(fsd_n),
      .sclk(sclk), .frame_sync_n(frame_sync_n), .din(din), .sec_frame(sec_frame));
   // Expected field outputs for given register contents.
   function automatic logic [22:0] exp_f(input logic [7:0] c1, c2, c3, c4);
      logic f;
      f = c2[7] & c2[6];
      exp_f = {c1[6:0], f, f, c2[4], c2[3], c2[6], c3[7:6], c4[3:0],
               (c4[6:4] == 3'h0) ? 4'h8 : {1'b0, c4[6:4]}, c4[7]};
   endfunction
   // Compares one value with its expectation and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Writes one register through a secondary word.
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      u_host.xfer({3'b000, a, v}, rb, fa);
   endtask
   // Reads one register through a secondary word.
   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      u_host.xfer({3'b001, a, 8'h00}, v, fa);
   endtask
   task automatic chk_fields();
      chk(32'(fields), 32'(exp_f(rg[1], rg[2], rg[3], rg[4])));
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Counts software reset pulses and cuts a hang short.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (soft_reset === 1'b1) begin
         sr_cnt <= sr_cnt + 1;
      end
      if (cyc == 60000) begin
         err_count++;
         give_verdict();
      end
   end
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      alt = 1'b0;
      ovf = 1'b0;
      for (j = 1; j <= 4; j++) rg[j] = 8'h00;
      void'($urandom(58327));
      repeat (8) @(negedge mclk);
      rst_n = 1'b1;
      chk_fields();
      chk(32'({fsd_n, flag0, flag1, soft_reset, dout_oe, dout}), 32'h20);
      // Every gain and divisor code, random flags and slave counts, then read back.
      for (j = 0; j < 8; j++) begin
         d = 8'($urandom);
         rg[1] = {1'b0, j[2:0], j[1:0], j[1:0]};
         rg[2] = {d[7], 1'b0, 1'b0, d[4:2], 2'b00};
         rg[3] = {d[7:6], 6'(18 + ($urandom % 46))};
         rg[4] = {j[0], j[2:0], j[1:0], ~j[1:0]};
         for (k = 1; k <= 4; k++) wr(5'(k), rg[k]);
         chk_fields();
         for (k = 1; k <= 4; k++) begin
            ovf = 1'($urandom);
            rd(5'(k), rb);
            d = (k == 2) ? {rg[2][7:6], ovf, rg[2][4:0]} : rg[k];
            chk(32'(rb), 32'(d));
         end
         ovf = 1'b0;
      end
      // No-op, unmapped and malformed words change nothing; no-op and unmapped addresses read as zero.
      wr(ADDR_NOP, 8'($urandom));
      wr(5'(5 + ($urandom % 27)), 8'hff);
      u_host.xfer({2'b01, 1'b0, ADDR_CTRL1, 8'h7f}, rb, fa);
      chk_fields();
      rd(ADDR_NOP, rb);
      chk(32'(rb), 32'h0);
      rd(5'h1f, rb);
      chk(32'(rb), 32'h0);
      // Software reset clears everything with a single pulse and no follow-up write.
      wr(ADDR_CTRL1, 8'hbf);
      for (k = 1; k <= 4; k++) rg[k] = 8'h00;
      chk_fields();
      chk(32'(sr_cnt), 32'h1);
      rd(ADDR_CTRL1, rb);
      chk(32'(rb), 32'h0);
      // Phone mode drives the flags and passes the alternate input out.
      rg[2] = 8'hc0;
      wr(ADDR_CTRL2, rg[2]);
      chk_fields();
      for (k = 0; k < 16; k++) begin
         alt = 1'($urandom);
         @(negedge mclk);
         chk(32'(dout), 32'(alt));
      end
      rg[2] = 8'h80;
      wr(ADDR_CTRL2, rg[2]);
      chk_fields();
      rg[2] = 8'h40;
      wr(ADDR_CTRL2, rg[2]);
      chk_fields();
      // A hardware reset in mid-run returns every register and pin to its default.
      wr(ADDR_CTRL4, 8'h5a);
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      for (k = 1; k <= 4; k++) rg[k] = 8'h00;
      chk_fields();
      chk(32'({fsd_n, flag0, flag1, soft_reset, dout_oe, dout}), 32'h20);
      @(negedge mclk);
      chk_fields();
      wr(ADDR_CTRL2, 8'h00);
      rg[2] = 8'h00;
      // Delayed sync lands on the programmed shift clock, or is skipped if too late.
      for (k = 0; k < 3; k++) begin
         d = (k == 0) ? 8'h12 : ((k == 1) ? 8'h17 : 8'h3f);
         wr(ADDR_CTRL3, d);
         u_host.xfer(16'h0000, rb, fa);
         chk(32'(fa), (d > 8'h18) ? 32'h0 : 32'(d));
      end
      give_verdict();
   end
endmodule
`default_nettype wire
